/* dv/i2c_master_model.sv */
// Two-wire bus master model: drives the serial clock and pulls data low.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/100ps
module i2c_master_model (
	output logic      o_scl,
	output logic      o_pull,
	input  wire logic i_sda
);
	// ==========================
	// Bus phases
	initial begin
		o_scl = 1'b1;
		o_pull = 1'b0;
	end
	task link_reset_pulse();
		#4 o_scl = 1'b0;
		#4 o_scl = 1'b1; // Data stays high: no start
		#8;
	endtask
	task start();
		o_pull = 1'b0;
		o_scl = 1'b1;
		#16 o_pull = 1'b1;
		#16 o_scl = 1'b0;
		#16;
	endtask
	task xbyte(input logic [8:0] d, output logic [8:0] r);
		for (int i = 8; i >= 0; i--) begin
			o_pull = !d[i];
			#16 o_scl = 1'b1;
			#16 r[i] = i_sda;
			#16 o_scl = 1'b0;
			#16;
		end
	endtask
	task stop();
		o_pull = 1'b1;
		#16 o_scl = 1'b1; // Clock stands high between frames
		#16 o_pull = 1'b0;
		#32;
	endtask
endmodule

/* dv/tb_dual_wiper_i2c_target.sv */
// Self-checking bench for the dual wiper target against a reference model.
// Assumes the master model and the bound checker.
`timescale 1ns/100ps
module tb_dual_wiper_i2c_target;
	logic       clk = 0, rst_n = 1, vsel = 0, s0 = 0, s1 = 0, sel = 0, h1, h2, so;
	wire        scl, pull, oe, sdo, sda;
	logic [7:0] c1, c2, t1, t2, code[2] = '{8'h80, 8'h80};
	logic       shd[2] = '{1'b0, 1'b0};
	logic [8:0] r;
	logic [6:0] adr;
	int         n_errors = 0, n_checks = 0;
	// ==========================
	// Wiring
	assign sda = !((oe & !sdo) | pull);
	always #4 clk = ~clk;
	dual_wiper_i2c_target dut_u (.i_core_clk(clk), .i_rst_n(rst_n), .i_scl(scl), .i_sda(sda), .o_sda(sdo),
		.o_sda_oe(oe), .i_strap_variant(vsel), .i_address_strap_bit_zero(s0), .i_address_strap_bit_one(s1),
		.o_wiper_code_register_1(c1), .o_wiper_code_register_2(c2), .o_tap_1(t1), .o_tap_2(t2),
		.o_shutdown_1(h1), .o_shutdown_2(h2), .o_channel_select_bit(so));
	i2c_master_model m_u (.o_scl(scl), .o_pull(pull), .i_sda(sda));
	task end_of_test();
		if (n_errors == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			n_errors++;
			$display("FAIL %s exp %h got %h", n, e, g);
		end
	endtask
	task all_chk();
		repeat (8) @(posedge clk);
		chk("code1", code[0], c1);
		chk("code2", code[1], c2);
		chk("tap1", shd[0] ? 8'h00 : code[0], t1);
		chk("tap2", shd[1] ? 8'h00 : code[1], t2);
		chk("shdn", {6'h00, shd[1], shd[0]}, {6'h00, h2, h1});
		chk("sel", {7'h00, sel}, {7'h00, so});
	endtask
	task wr(input logic [7:0] ins, input int n, input logic hit);
		logic [7:0] d;
		m_u.start();
		m_u.xbyte({adr, 2'b01}, r);
		chk("ack_a", {7'h00, !hit}, {7'h00, r[0]});
		m_u.xbyte({ins, 1'b1}, r);
		if (hit) begin
			sel = ins[7];
			shd[ins[7]] = ins[6];
		end
		repeat (n) begin
			d = 8'($urandom);
			m_u.xbyte({d, 1'b1}, r);
			chk("ack_d", {7'h00, !hit}, {7'h00, r[0]});
			if (hit)
				code[sel] = d;
		end
		m_u.stop();
		all_chk();
	endtask
	task rd(input int n);
		m_u.start();
		m_u.xbyte({adr, 2'b11}, r);
		chk("ack_r", 8'h00, {7'h00, r[0]});
		for (int i = 0; i < n; i++) begin
			m_u.xbyte({8'hFF, i == n - 1}, r);
			chk("rdata", code[sel], r[8:1]);
		end
		m_u.stop();
	endtask
	// ==========================
	// Sequence
	initial begin
		void'($urandom(32'hB905));
		rst_n <= 1'b0;
		m_u.link_reset_pulse();
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		all_chk();
		adr = 7'h2F;
		wr({2'b00, 6'($urandom)}, 1, 1'b1);
		wr({2'b10, 6'($urandom)}, 3, 1'b1);
		adr = 7'h2E;
		wr(8'h00, 1, 1'b0);
		adr = 7'h2F;
		wr(8'h40, 2, 1'b1);
		wr(8'h00, 0, 1'b1);
		rd(2);
		wr(8'h80, 0, 1'b1);
		rd(3);
		@(posedge clk) begin
			vsel <= 1'b1;
			s0 <= 1'($urandom);
			s1 <= 1'($urandom);
		end
		repeat (4) @(posedge clk);
		adr = {5'h0B, !s1, s0};
		wr(8'h00, 1, 1'b0);
		adr = {5'h0B, s1, s0};
		wr(8'hC0, 1, 1'b1);
		rd(1);
		end_of_test();
	end
	initial begin
		#200000;
		n_errors++;
		end_of_test();
	end
endmodule

/* dv/wiper_i2c_asserts.sv */
// Checker on the wiper target ports, core clock domain only.
// Assumes taps follow codes one core cycle later.
`timescale 1ns/100ps
module wiper_i2c_asserts (
	input wire logic       i_core_clk,
	input wire logic       i_rst_n,
	input wire logic       i_scl,
	input wire logic       o_sda,
	input wire logic       o_sda_oe,
	input wire logic [7:0] o_wiper_code_register_1,
	input wire logic [7:0] o_wiper_code_register_2,
	input wire logic [7:0] o_tap_1,
	input wire logic [7:0] o_tap_2,
	input wire logic       o_shutdown_1,
	input wire logic       o_shutdown_2
);
	// ==========================
	// Properties
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);
	shut_tap1_a: assert property ($past(o_shutdown_1) |-> o_tap_1 == 8'h00) else $error("tap1 not zero");
	shut_tap2_a: assert property ($past(o_shutdown_2) |-> o_tap_2 == 8'h00) else $error("tap2 not zero");
	code_tap1_a: assert property (!$past(o_shutdown_1) |-> o_tap_1 == $past(o_wiper_code_register_1))
		else $error("tap1 wrong");
	code_tap2_a: assert property (!$past(o_shutdown_2) |-> o_tap_2 == $past(o_wiper_code_register_2))
		else $error("tap2 wrong");
	keep_code1_a: assert property ($rose(o_shutdown_1) |-> $stable(o_wiper_code_register_1))
		else $error("code1 moved");
	keep_code2_a: assert property ($rose(o_shutdown_2) |-> $stable(o_wiper_code_register_2))
		else $error("code2 moved");
	drive_low_a: assert property (o_sda == 1'b0) else $error("sda not open drain");
	ack_edge_a: assert property ($changed(o_sda_oe) |-> !i_scl) else $error("sda moved, clock high");
endmodule
bind dual_wiper_i2c_target wiper_i2c_asserts chk_u (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_scl(i_scl),
	.o_sda(o_sda), .o_sda_oe(o_sda_oe), .o_wiper_code_register_1(o_wiper_code_register_1),
	.o_wiper_code_register_2(o_wiper_code_register_2), .o_tap_1(o_tap_1), .o_tap_2(o_tap_2),
	.o_shutdown_1(o_shutdown_1), .o_shutdown_2(o_shutdown_2));

/* hw/dual_wiper_i2c_target.sv */
// Two-wire target for two 8-bit wiper code registers with shutdown.
// Assumes the serial clock pin also clocks the link logic; data pin sampled on it.
`timescale 1ns/100ps
module dual_wiper_i2c_target (
	input  wire logic       i_core_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_scl,
	input  wire logic       i_sda,
	output logic            o_sda,
	output logic            o_sda_oe,
	input  wire logic       i_strap_variant,
	input  wire logic       i_address_strap_bit_zero,
	input  wire logic       i_address_strap_bit_one,
	output logic [7:0]      o_wiper_code_register_1,
	output logic [7:0]      o_wiper_code_register_2,
	output logic [7:0]      o_tap_1,
	output logic [7:0]      o_tap_2,
	output logic            o_shutdown_1,
	output logic            o_shutdown_2,
	output logic            o_channel_select_bit
);

	// ==========================================
	// Start and stop detect, link domain
	// Data edges under a high clock flip a toggle; the link answers it
	// on its next rising clock. A level flag would re-arm on every low
	// data bit under a rising clock and fake a start.
	logic start_tgl_r;
	logic stop_tgl_r;
	logic start_ack_r;
	logic stop_ack_r;
	logic start_pend;
	logic stop_pend;
	logic rst_link_n;

	assign rst_link_n = i_rst_n;

	always_ff @(negedge i_sda or negedge i_rst_n) begin
		if (!i_rst_n) begin
			start_tgl_r <= 1'b0;
		end else if (i_scl) begin
			start_tgl_r <= ~start_tgl_r;
		end
	end

	always_ff @(posedge i_sda or negedge i_rst_n) begin
		if (!i_rst_n) begin
			stop_tgl_r <= 1'b0;
		end else if (i_scl) begin
			stop_tgl_r <= ~stop_tgl_r;
		end
	end

	assign start_pend = start_tgl_r ^ start_ack_r;
	assign stop_pend  = stop_tgl_r ^ stop_ack_r;

	always_ff @(posedge i_scl) begin
		if (!rst_link_n) begin
			start_ack_r <= 1'b0;
			stop_ack_r  <= 1'b0;
		end else begin
			start_ack_r <= start_tgl_r;
			stop_ack_r  <= stop_tgl_r;
		end
	end

	// ==========================================
	// Strap capture and address
	logic [1:0] strap_s1_r;
	logic [1:0] strap_s2_r;
	logic       variant_s1_r;
	logic       variant_s2_r;
	logic [6:0] own_addr;

	always_ff @(posedge i_core_clk) begin
		strap_s1_r   <= {i_address_strap_bit_one, i_address_strap_bit_zero};
		strap_s2_r   <= strap_s1_r;
		variant_s1_r <= i_strap_variant;
		variant_s2_r <= variant_s1_r;
	end

	// Straps are static; link samples the synchronised copy
	assign own_addr = variant_s2_r ? {wiper_pkg::STRAP_ADDR_HI, strap_s2_r}
	                               : wiper_pkg::FIXED_ADDR;

	// ==========================================
	// Link shifter on the serial clock
	wiper_pkg::phase_t     phase_r;
	logic [3:0]            bit_cnt_r;
	logic [7:0]            shift_r;
	logic                  ack_r;
	logic                  upd_tgl_r;
	wiper_pkg::wiper_upd_t upd_r;
	logic                  sel_link_r;
	logic [7:0]            rd_code;
	logic [7:0]            shift_nxt;
	logic                  rx_phase;
	logic                  byte_end;
	logic                  addr_hit;

	function automatic logic [3:0] cnt_inc(input logic [3:0] c);
		return c + wiper_pkg::BIT_COUNT_STEP;
	endfunction

	assign shift_nxt = {shift_r[6:0], i_sda};
	assign rx_phase  = (phase_r == wiper_pkg::PH_ADDR) || (phase_r == wiper_pkg::PH_INSTR)
	                   || (phase_r == wiper_pkg::PH_DATA);
	// Eighth bit of a received byte arrives on this rising clock
	assign byte_end  = !start_pend && !stop_pend && !ack_r && rx_phase
	                   && (bit_cnt_r == wiper_pkg::BIT_COUNT_LAST);
	assign addr_hit  = (shift_nxt[7:1] == own_addr);
	// Core registers are quasi-static during a read byte
	assign rd_code = sel_link_r ? o_wiper_code_register_2 : o_wiper_code_register_1;

	// ==========================================
	// Link phase
	always_ff @(posedge i_scl) begin
		if (!rst_link_n) begin
			phase_r <= wiper_pkg::PH_IDLE;
		end else if (start_pend) begin
			phase_r <= wiper_pkg::PH_ADDR;
		end else if (stop_pend) begin
			phase_r <= wiper_pkg::PH_IDLE;
		end else if (!ack_r) begin
			case (phase_r)
				wiper_pkg::PH_IDLE: begin
					phase_r <= wiper_pkg::PH_IDLE;
				end
				wiper_pkg::PH_ADDR: begin
					if (byte_end) begin
						if (addr_hit) begin
							phase_r <= shift_nxt[0] ? wiper_pkg::PH_READ
							                        : wiper_pkg::PH_INSTR;
						end else begin
							phase_r <= wiper_pkg::PH_IDLE;
						end
					end
				end
				wiper_pkg::PH_INSTR: begin
					// One instruction per transaction; later bytes are data
					if (byte_end) begin
						phase_r <= wiper_pkg::PH_DATA;
					end
				end
				wiper_pkg::PH_DATA: begin
					phase_r <= wiper_pkg::PH_DATA;
				end
				wiper_pkg::PH_READ: begin
					// Master acknowledge: high means done
					if (bit_cnt_r == wiper_pkg::BIT_COUNT_ACK && i_sda) begin
						phase_r <= wiper_pkg::PH_IDLE;
					end
				end
				default: begin
					phase_r <= wiper_pkg::PH_IDLE;
				end
			endcase
		end
	end

	// ==========================================
	// Bit counter
	always_ff @(posedge i_scl) begin
		if (!rst_link_n) begin
			bit_cnt_r <= wiper_pkg::BIT_COUNT_ZERO;
		end else if (start_pend) begin
			// First address bit is taken on the start's rising clock
			bit_cnt_r <= wiper_pkg::BIT_COUNT_STEP;
		end else if (stop_pend) begin
			bit_cnt_r <= bit_cnt_r;
		end else if (ack_r) begin
			bit_cnt_r <= wiper_pkg::BIT_COUNT_ZERO;
		end else if (rx_phase) begin
			bit_cnt_r <= cnt_inc(bit_cnt_r);
		end else if (phase_r == wiper_pkg::PH_READ) begin
			if (bit_cnt_r == wiper_pkg::BIT_COUNT_ACK) begin
				bit_cnt_r <= wiper_pkg::BIT_COUNT_ZERO;
			end else begin
				bit_cnt_r <= cnt_inc(bit_cnt_r);
			end
		end
	end

	// ==========================================
	// Receive shifter
	always_ff @(posedge i_scl) begin
		if (!rst_link_n) begin
			shift_r <= 8'h00;
		end else if (start_pend) begin
			shift_r <= {7'h00, i_sda};
		end else if (!stop_pend && !ack_r && rx_phase) begin
			shift_r <= shift_nxt;
		end
	end

	// ==========================================
	// Acknowledge request, one pulse per accepted byte
	always_ff @(posedge i_scl) begin
		if (!rst_link_n) begin
			ack_r <= 1'b0;
		end else if (byte_end) begin
			ack_r <= (phase_r != wiper_pkg::PH_ADDR) || addr_hit;
		end else begin
			ack_r <= 1'b0;
		end
	end

	// ==========================================
	// Channel kept across transactions for reads
	always_ff @(posedge i_scl) begin
		if (!rst_link_n) begin
			sel_link_r <= 1'b0;
		end else if (byte_end && phase_r == wiper_pkg::PH_INSTR) begin
			// Low six bits dropped here
			sel_link_r <= shift_nxt[wiper_pkg::INSTR_CHAN_BIT];
		end
	end

	// ==========================================
	// Update payload and toggle toward the core
	// Payload set on the same edge as the toggle and then held a byte time
	always_ff @(posedge i_scl) begin
		if (!rst_link_n) begin
			upd_r     <= '0;
			upd_tgl_r <= 1'b0;
		end else if (byte_end && phase_r == wiper_pkg::PH_INSTR) begin
			upd_r     <= '{chan: shift_nxt[wiper_pkg::INSTR_CHAN_BIT],
			               shdn: shift_nxt[wiper_pkg::INSTR_SHDN_BIT],
			               load: 1'b0, code: 8'h00};
			upd_tgl_r <= ~upd_tgl_r;
		end else if (byte_end && phase_r == wiper_pkg::PH_DATA) begin
			upd_r.load <= 1'b1;
			upd_r.code <= shift_nxt;
			upd_tgl_r  <= ~upd_tgl_r;
		end
	end

	// ==========================================
	// Data pin drive, changed on falling clock only
	logic       drive_low_r;
	logic [7:0] rd_shift_r;

	always_ff @(negedge i_scl) begin
		if (!rst_link_n) begin
			drive_low_r <= 1'b0;
			rd_shift_r  <= 8'h00;
		end else if (ack_r) begin
			drive_low_r <= 1'b1;
			rd_shift_r  <= rd_code;
		end else if (phase_r == wiper_pkg::PH_READ && bit_cnt_r != wiper_pkg::BIT_COUNT_ACK) begin
			drive_low_r <= ~rd_shift_r[7];
			rd_shift_r  <= {rd_shift_r[6:0], 1'b0};
		end else if (phase_r == wiper_pkg::PH_READ) begin
			drive_low_r <= 1'b0;
			rd_shift_r  <= rd_code;
		end else begin
			drive_low_r <= 1'b0;
		end
	end

	// Read phase entered on the eighth address bit's rising clock, before the acknowledge
	assign o_sda    = 1'b0;
	assign o_sda_oe = drive_low_r;

	// ==========================================
	// Update crossing into core domain
	logic upd_s1_r;
	logic upd_s2_r;
	logic upd_s3_r;
	logic upd_pulse;

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			upd_s1_r <= 1'b0;
			upd_s2_r <= 1'b0;
			upd_s3_r <= 1'b0;
		end else begin
			upd_s1_r <= upd_tgl_r;
			upd_s2_r <= upd_s1_r;
			upd_s3_r <= upd_s2_r;
		end
	end
	// Payload stable for a full byte time before the next toggle
	assign upd_pulse = upd_s2_r ^ upd_s3_r;

	// ==========================================
	// Wiper registers and shutdown
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_wiper_code_register_1 <= wiper_pkg::WIPER_MIDSCALE;
			o_wiper_code_register_2 <= wiper_pkg::WIPER_MIDSCALE;
		end else if (upd_pulse && upd_r.load) begin
			// Loaded regardless of shutdown
			if (upd_r.chan)
				o_wiper_code_register_2 <= upd_r.code;
			else
				o_wiper_code_register_1 <= upd_r.code;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_shutdown_1         <= 1'b0;
			o_shutdown_2         <= 1'b0;
			o_channel_select_bit <= 1'b0;
		end else if (upd_pulse && !upd_r.load) begin
			o_channel_select_bit <= upd_r.chan;
			if (upd_r.chan)
				o_shutdown_2 <= upd_r.shdn;
			else
				o_shutdown_1 <= upd_r.shdn;
		end
	end

	// Shutdown forces tap to lower end; code kept
	function automatic logic [7:0] applied_tap(input logic shdn, input logic [7:0] code);
		return shdn ? 8'h00 : code;
	endfunction

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_tap_1 <= wiper_pkg::WIPER_MIDSCALE;
			o_tap_2 <= wiper_pkg::WIPER_MIDSCALE;
		end else begin
			o_tap_1 <= applied_tap(o_shutdown_1, o_wiper_code_register_1);
			o_tap_2 <= applied_tap(o_shutdown_2, o_wiper_code_register_2);
		end
	end

endmodule

/* hw/wiper_pkg.sv */
// Constants and carrier types for the dual wiper two-wire target.
// Assumes a core clock domain and a link domain clocked by the serial clock line.
//
// How it works
// - Data falls while clock high starts transaction
// - First byte: seven-bit address plus direction bit
// - Matching address acknowledged on ninth pulse
// - Mismatch stays idle until next start
// - Fixed address variant or two strap pins
// - Instruction MSB selects wiper channel
// - Second MSB shuts selected channel down
// - Shutdown keeps stored code, release restores
// - Codes still accepted while shut down
// - Low six instruction bits ignored
// - Data byte after instruction loads wiper code
// - Nine pulses per byte, eight plus acknowledge
// - Data changes only while clock low
// - Read data follows address acknowledge directly
// - Read returns last selected channel
// - Instruction-only write updates channel selection
// - Stop returns device to idle
// - Further write bytes update selected wiper
// - Acknowledged reads repeat the wiper code
// - Both wipers preset to midscale at power-up
// - Eight-bit code selects one of 256 taps
// - Strap pins give two address LSBs
package wiper_pkg;

	// ==========================================
	// Address and field layout
	localparam logic [6:0] FIXED_ADDR      = 7'h2F;
	localparam logic [4:0] STRAP_ADDR_HI   = 5'h0B;
	localparam int         INSTR_CHAN_BIT  = 7;
	localparam int         INSTR_SHDN_BIT  = 6;
	localparam logic [7:0] WIPER_MIDSCALE  = 8'h80;
	localparam logic [3:0] BIT_COUNT_LAST  = 4'h7;
	localparam logic [3:0] BIT_COUNT_ZERO  = 4'h0;
	localparam logic [3:0] BIT_COUNT_STEP  = 4'h1;
	localparam logic [3:0] BIT_COUNT_ACK   = 4'h8;

	// ==========================================
	// Link phases
	typedef enum logic [4:0] {
		PH_IDLE  = 5'h01,
		PH_ADDR  = 5'h02,
		PH_INSTR = 5'h04,
		PH_DATA  = 5'h08,
		PH_READ  = 5'h10
	} phase_t;

	// Update handed from link to core domain
	typedef struct packed {
		logic       chan;
		logic       shdn;
		logic       load;
		logic [7:0] code;
	} wiper_upd_t;

endpackage
